// [inc/tpm_pkg.sv]
// Constants, carriers and decode helpers for the timer pin mode select block
package tpm_pkg;
    // Widths
    localparam int CNT_W = 16;
    localparam int PIN_CNT = 3;
    // Register offsets (8-bit plain port)
    localparam logic [2:0] OFS_CH0_CTRL_HIGH = 3'h0;
    localparam logic [2:0] OFS_CH0_CTRL_LOW = 3'h1;
    localparam logic [2:0] OFS_CH1_CTRL = 3'h2;
    localparam logic [2:0] OFS_CH2_CTRL = 3'h3;
    localparam logic [2:0] OFS_MODE_CTRL = 3'h4;
    localparam logic [2:0] OFS_PIN_STATUS = 3'h5;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    // Field positions in the mode control register
    localparam int POS_BUFFER_MODE_A = 0;
    localparam int POS_PRESCALE_LSB = 4;
    localparam int POS_PRESCALE_MSB = 6;
    localparam logic [2:0] PRESCALE_UNDIVIDED = 3'h0;
    // Pin status field positions
    localparam int POS_LEVEL_LSB = 0;
    localparam int POS_OE_N_LSB = 4;
    // Pin indices
    localparam int PIN_CH0_A = 0;
    localparam int PIN_CH0_C = 1;
    localparam int PIN_CH1_A = 2;

    // Pin drive carrier: level and active-low output enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } tpm_pin_drv_t;

    // Capture result carrier
    typedef struct packed {
        logic pulse;
        logic [CNT_W-1:0] value;
    } tpm_capture_t;

    // Field is in compare mode
    function automatic logic is_compare(input logic [3:0] f);
        return f[3] == 1'b0;
    endfunction

    // Field is capture from another source
    function automatic logic is_ext_capture(input logic [3:0] f);
        return f[3:2] == 2'b11;
    endfunction
endpackage

// [logic/tpm_sync2.sv]
// Two-stage synchroniser for the timer pins
`timescale 1ns/10ps
module tpm_sync2 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Raw and synchronised pins
    input wire logic [tpm_pkg::PIN_CNT-1:0] raw_in,
    output logic [tpm_pkg::PIN_CNT-1:0] sync_out
);
    typedef struct packed {
        logic [tpm_pkg::PIN_CNT-1:0] s1;
        logic [tpm_pkg::PIN_CNT-1:0] s2;
    } tpm_sync_state_t;

    tpm_sync_state_t s_reg;
    tpm_sync_state_t s_next;

    // First stage feeds only the second
    always_comb begin
        s_next.s1 = raw_in;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.s2;
endmodule // tpm_sync2

// [logic/tpm_pin_unit.sv]
// One compare/capture pin: mode decode, pin drive and counter capture
`timescale 1ns/10ps
module tpm_pin_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Mode field
    input wire logic [3:0] field_in,
    input wire logic field_wr_in,
    input wire logic enable_in,
    // Event sources
    input wire logic pin_sync_in,
    input wire logic match_in,
    input wire logic ext_event_in,
    input wire logic [tpm_pkg::CNT_W-1:0] count_in,
    // Results
    output tpm_pkg::tpm_pin_drv_t pin_out,
    output logic event_out,
    output tpm_pkg::tpm_capture_t cap_out
);
    typedef struct packed {
        tpm_pkg::tpm_pin_drv_t drv;
        logic pin_prev;
        logic event_p;
        tpm_pkg::tpm_capture_t cap;
    } tpm_unit_state_t;

    tpm_unit_state_t s_reg;
    tpm_unit_state_t s_next;
    logic cmp_on;
    logic rise;
    logic fall;
    logic cap_hit;

    // Decode of the field
    always_comb begin
        cmp_on = tpm_pkg::is_compare(field_in) && (field_in[1:0] != 2'b00);
        rise = pin_sync_in && !s_reg.pin_prev;
        fall = !pin_sync_in && s_reg.pin_prev;
        cap_hit = 1'b0;
        if (field_in[3:2] == 2'b10) begin
            if (field_in[1]) begin
                cap_hit = rise || fall;
            end else if (field_in[0]) begin
                cap_hit = fall;
            end else begin
                cap_hit = rise;
            end
        end else if (tpm_pkg::is_ext_capture(field_in)) begin
            cap_hit = ext_event_in;
        end
        cap_hit = cap_hit && enable_in;
    end

    // Next state: a fresh write wins over a match in the same cycle
    always_comb begin
        s_next = s_reg;
        s_next.pin_prev = pin_sync_in;
        s_next.drv.oe_n = !cmp_on;
        s_next.event_p = cap_hit || (cmp_on && match_in && enable_in);
        s_next.cap.pulse = cap_hit;
        if (cap_hit) begin
            s_next.cap.value = count_in;
        end
        if (field_wr_in && cmp_on) begin
            s_next.drv.level = field_in[2];
        end else if (cmp_on && match_in && enable_in) begin
            unique case (field_in[1:0])
                2'b01: s_next.drv.level = 1'b0;
                2'b10: s_next.drv.level = 1'b1;
                2'b11: s_next.drv.level = !s_reg.drv.level;
                default: s_next.drv.level = s_reg.drv.level;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_reg <= '{drv: '{level: 1'b0, oe_n: 1'b1}, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_out = s_reg.drv;
    assign event_out = s_reg.event_p;
    assign cap_out = s_reg.cap;

    sequence seq_wr_cmp(logic [1:0] top);
        field_wr_in && field_in[3:2] == top && field_in[1:0] != 2'b00;
    endsequence

    // Match seen in compare mode with no write pulse competing
    sequence seq_match(logic [1:0] act);
        match_in && enable_in && !field_wr_in && field_in[3] == 1'b0 && field_in[1:0] == act;
    endsequence

    chk_init_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        seq_wr_cmp(2'b00) |=> pin_out.level == 1'b0 && pin_out.oe_n == 1'b0)
        else $error("initial low level not applied");
    chk_init_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        seq_wr_cmp(2'b01) |=> pin_out.level == 1'b1 && pin_out.oe_n == 1'b0)
        else $error("initial high level not applied");
    chk_out_disable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (field_in[3] == 1'b0 && field_in[1:0] == 2'b00) |=> pin_out.oe_n == 1'b1)
        else $error("pin driven while output disabled");
    chk_match_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        seq_match(2'b01) |=> pin_out.level == 1'b0)
        else $error("match did not drive low");
    chk_match_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        seq_match(2'b10) |=> pin_out.level == 1'b1)
        else $error("match did not drive high");
    chk_match_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        seq_match(2'b11) |=> pin_out.level != $past(pin_out.level))
        else $error("match did not toggle");
    chk_cap_rise: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (enable_in && field_in == 4'b1000 && !s_reg.pin_prev && pin_sync_in)
        |=> cap_out.pulse && cap_out.value == $past(count_in))
        else $error("rising edge capture missed");
    chk_cap_fall: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (field_in == 4'b1001 && s_reg.pin_prev && !pin_sync_in)
        |=> cap_out.pulse == $past(enable_in))
        else $error("falling edge capture wrong");
    chk_cap_both: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (enable_in && field_in[3:1] == 3'b101 && (s_reg.pin_prev != pin_sync_in))
        |=> cap_out.pulse)
        else $error("both edge capture missed");
endmodule // tpm_pin_unit

// [logic/tpm_top.sv]
// Timer pin mode select: registers, pin sync and three compare/capture pins
//
// Functional notes
// - Field 00xx with nonzero low bits makes a compare register whose pin starts low.
// - Field 01xx starts the pin high, and low bits 00 turn the pin output off.
// - Compare mode with low bits 01 drives the pin low on each match.
// - Compare mode with low bits 10 drives the pin high on each match.
// - Compare mode with low bits 11 inverts the pin on each match.
// - Field 10xx makes a capture register fed by its own pin.
// - Pin capture with low bits 00 latches the counter on a rising edge.
// - Pin capture with low bits 01 latches the counter on a falling edge.
// - Pin capture with bit 1 set latches the counter on both edges.
// - Channel 0 field 11xx captures on every count step of channel 1.
// - That count capture never fires while channel 1 prescale select is 000.
// - With buffer mode A set, channel 0 register C makes no capture or compare event.
// - Channel 1 register A field 11xx captures on each channel 0 register A capture, or match while its pin output is on.
`timescale 1ns/10ps
module tpm_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Counter side strobes and values
    input wire logic ch0_match_a_in,
    input wire logic ch0_match_c_in,
    input wire logic ch1_match_a_in,
    input wire logic ch1_count_step_in,
    input wire logic [tpm_pkg::CNT_W-1:0] ch0_counter_in,
    input wire logic [tpm_pkg::CNT_W-1:0] ch1_counter_in,
    // Timer pins, split into input, output and active-low enable
    input wire logic ch0_pin_a_in,
    input wire logic ch0_pin_c_in,
    input wire logic ch1_pin_a_in,
    output logic ch0_pin_a_out,
    output logic ch0_pin_a_oe_n_out,
    output logic ch0_pin_c_out,
    output logic ch0_pin_c_oe_n_out,
    output logic ch1_pin_a_out,
    output logic ch1_pin_a_oe_n_out,
    // Capture results
    output tpm_pkg::tpm_capture_t ch0_cap_a_out,
    output tpm_pkg::tpm_capture_t ch0_cap_c_out,
    output tpm_pkg::tpm_capture_t ch1_cap_a_out
);
    typedef struct packed {
        logic [7:0] ch0_pin_control_high;
        logic [7:0] ch0_pin_control_low;
        logic [7:0] ch1_pin_control;
        logic [7:0] ch2_pin_control;
        logic [7:0] mode_ctrl;
        logic [tpm_pkg::PIN_CNT-1:0] field_wr;
        logic [7:0] rd_data;
    } tpm_top_state_t;

    tpm_top_state_t s_reg;
    tpm_top_state_t s_next;
    logic [tpm_pkg::PIN_CNT-1:0] pin_sync;
    tpm_pkg::tpm_pin_drv_t drv [tpm_pkg::PIN_CNT];
    logic [tpm_pkg::PIN_CNT-1:0] evt;
    logic buffer_mode_a;
    logic [2:0] ch1_prescale_sel;
    logic ch1_count_ok;
    logic [7:0] pin_status;

    // Mode bits that steer the pin units
    assign buffer_mode_a = s_reg.mode_ctrl[tpm_pkg::POS_BUFFER_MODE_A];
    assign ch1_prescale_sel = s_reg.mode_ctrl[tpm_pkg::POS_PRESCALE_MSB:tpm_pkg::POS_PRESCALE_LSB];
    // Undivided clock makes every cycle a step, so count capture is off
    assign ch1_count_ok = ch1_count_step_in &&
        (ch1_prescale_sel != tpm_pkg::PRESCALE_UNDIVIDED);

    // Live pin state for software
    always_comb begin
        pin_status = 8'h00;
        for (int i = 0; i < tpm_pkg::PIN_CNT; i++) begin
            pin_status[tpm_pkg::POS_LEVEL_LSB + i] = drv[i].level;
            pin_status[tpm_pkg::POS_OE_N_LSB + i] = drv[i].oe_n;
        end
    end

    // Register writes and reads; unmapped reads return zero
    always_comb begin
        s_next = s_reg;
        s_next.field_wr = '0;
        s_next.rd_data = 8'h00;
        if (wr_en_in) begin
            unique case (addr_in)
                tpm_pkg::OFS_CH0_CTRL_HIGH: begin
                    s_next.ch0_pin_control_high = wr_data_in;
                    s_next.field_wr[tpm_pkg::PIN_CH0_A] = 1'b1;
                end
                tpm_pkg::OFS_CH0_CTRL_LOW: begin
                    s_next.ch0_pin_control_low = wr_data_in;
                    s_next.field_wr[tpm_pkg::PIN_CH0_C] = 1'b1;
                end
                tpm_pkg::OFS_CH1_CTRL: begin
                    s_next.ch1_pin_control = wr_data_in;
                    s_next.field_wr[tpm_pkg::PIN_CH1_A] = 1'b1;
                end
                tpm_pkg::OFS_CH2_CTRL: s_next.ch2_pin_control = wr_data_in;
                tpm_pkg::OFS_MODE_CTRL: s_next.mode_ctrl = wr_data_in;
                default: s_next.field_wr = '0;
            endcase
        end
        if (rd_en_in) begin
            unique case (addr_in)
                tpm_pkg::OFS_CH0_CTRL_HIGH: s_next.rd_data = s_reg.ch0_pin_control_high;
                tpm_pkg::OFS_CH0_CTRL_LOW: s_next.rd_data = s_reg.ch0_pin_control_low;
                tpm_pkg::OFS_CH1_CTRL: s_next.rd_data = s_reg.ch1_pin_control;
                tpm_pkg::OFS_CH2_CTRL: s_next.rd_data = s_reg.ch2_pin_control;
                tpm_pkg::OFS_MODE_CTRL: s_next.rd_data = s_reg.mode_ctrl;
                tpm_pkg::OFS_PIN_STATUS: s_next.rd_data = pin_status;
                default: s_next.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_reg <= '{mode_ctrl: tpm_pkg::RST_MODE, rd_data: 8'h00,
                field_wr: '0, default: tpm_pkg::RST_CTRL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data_out = s_reg.rd_data;

    // Pins cross into the clock domain before any decode
    tpm_sync2 u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .raw_in({ch1_pin_a_in, ch0_pin_c_in, ch0_pin_a_in}),
        .sync_out(pin_sync)
    );

    // Channel 0 register A, count capture from channel 1
    tpm_pin_unit u_ch0_a (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .field_in(s_reg.ch0_pin_control_high[3:0]),
        .field_wr_in(s_reg.field_wr[tpm_pkg::PIN_CH0_A]),
        .enable_in(1'b1),
        .pin_sync_in(pin_sync[tpm_pkg::PIN_CH0_A]),
        .match_in(ch0_match_a_in),
        .ext_event_in(ch1_count_ok),
        .count_in(ch0_counter_in),
        .pin_out(drv[tpm_pkg::PIN_CH0_A]),
        .event_out(evt[tpm_pkg::PIN_CH0_A]),
        .cap_out(ch0_cap_a_out)
    );

    // Channel 0 register C, silenced while it serves as buffer
    tpm_pin_unit u_ch0_c (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .field_in(s_reg.ch0_pin_control_low[3:0]),
        .field_wr_in(s_reg.field_wr[tpm_pkg::PIN_CH0_C]),
        .enable_in(!buffer_mode_a),
        .pin_sync_in(pin_sync[tpm_pkg::PIN_CH0_C]),
        .match_in(ch0_match_c_in),
        .ext_event_in(ch1_count_ok),
        .count_in(ch0_counter_in),
        .pin_out(drv[tpm_pkg::PIN_CH0_C]),
        .event_out(evt[tpm_pkg::PIN_CH0_C]),
        .cap_out(ch0_cap_c_out)
    );

    // Channel 1 register A, chained to channel 0 register A events
    tpm_pin_unit u_ch1_a (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .field_in(s_reg.ch1_pin_control[3:0]),
        .field_wr_in(s_reg.field_wr[tpm_pkg::PIN_CH1_A]),
        .enable_in(1'b1),
        .pin_sync_in(pin_sync[tpm_pkg::PIN_CH1_A]),
        .match_in(ch1_match_a_in),
        .ext_event_in(evt[tpm_pkg::PIN_CH0_A]),
        .count_in(ch1_counter_in),
        .pin_out(drv[tpm_pkg::PIN_CH1_A]),
        .event_out(evt[tpm_pkg::PIN_CH1_A]),
        .cap_out(ch1_cap_a_out)
    );

    // Pin drivers come straight from the unit flip-flops
    assign ch0_pin_a_out = drv[tpm_pkg::PIN_CH0_A].level;
    assign ch0_pin_a_oe_n_out = drv[tpm_pkg::PIN_CH0_A].oe_n;
    assign ch0_pin_c_out = drv[tpm_pkg::PIN_CH0_C].level;
    assign ch0_pin_c_oe_n_out = drv[tpm_pkg::PIN_CH0_C].oe_n;
    assign ch1_pin_a_out = drv[tpm_pkg::PIN_CH1_A].level;
    assign ch1_pin_a_oe_n_out = drv[tpm_pkg::PIN_CH1_A].oe_n;

    chk_count_cap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_reg.ch0_pin_control_high[3:2] == 2'b11 && ch1_count_step_in &&
        ch1_prescale_sel != tpm_pkg::PRESCALE_UNDIVIDED) |=> ch0_cap_a_out.pulse)
        else $error("count step capture missed");
    chk_prescale_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_reg.ch0_pin_control_high[3:2] == 2'b11 &&
        ch1_prescale_sel == tpm_pkg::PRESCALE_UNDIVIDED)
        |=> !ch0_cap_a_out.pulse)
        else $error("capture with undivided count clock");
    chk_buffer_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        buffer_mode_a |=> !ch0_cap_c_out.pulse && !evt[tpm_pkg::PIN_CH0_C])
        else $error("buffer register made an event");
    chk_chain_cap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_reg.ch1_pin_control[3:2] == 2'b11 && evt[tpm_pkg::PIN_CH0_A])
        |=> ch1_cap_a_out.pulse && ch1_cap_a_out.value == $past(ch1_counter_in))
        else $error("chained capture missed");
    chk_write_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_en_in && addr_in == tpm_pkg::OFS_CH1_CTRL && wr_data_in[3] == 1'b0 &&
        wr_data_in[1:0] != 2'b00)
        |=> ##1 ch1_pin_a_out == $past(wr_data_in[2], 2) && !ch1_pin_a_oe_n_out)
        else $error("initial level not applied after write");
endmodule // tpm_top

// [dv/tpm_pin_partner.sv]
// Model of the external logic that drives or samples the three timer pins
`timescale 1ns/10ps
module tpm_pin_partner (
    // Clock
    input wire logic clk_in,
    // Levels the far side drives when enabled
    input wire logic [2:0] ext_lvl_in,
    input wire logic [2:0] ext_en_in,
    // Timer pin drive, active-low enable
    input wire logic [2:0] dut_lvl_in,
    input wire logic [2:0] dut_oe_n_in,
    // Resolved pin levels
    output logic [2:0] wire_out
);
    // Defined start so a floating pin never reads as unknown
    logic [2:0] float_reg = 3'h0;

    // Undriven pins wander each cycle so a stale level never looks valid
    always @(posedge clk_in) begin
        float_reg <= ~wire_out;
    end

    // Timer drive first, then far side, then the wandering level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (dut_oe_n_in[i] == 1'b0) begin
                wire_out[i] = dut_lvl_in[i];
            end else if (ext_en_in[i] == 1'b1) begin
                wire_out[i] = ext_lvl_in[i];
            end else begin
                wire_out[i] = float_reg[i];
            end
        end
    end
endmodule // tpm_pin_partner

// [dv/timer_pin_io_mode_select_tb_top.sv]
// Self-checking bench for the timer pin mode select block
`timescale 1ns/10ps
module timer_pin_io_mode_select_tb_top;
    logic clk_in;
    logic sys_rst_in;
    logic [2:0] addr_in;
    logic [7:0] wr_data_in;
    logic wr_en_in;
    logic rd_en_in;
    logic [7:0] rd_data_out;
    logic [2:0] match_in;
    logic step_in;
    logic [tpm_pkg::CNT_W-1:0] cnt0_in;
    logic [tpm_pkg::CNT_W-1:0] cnt1_in;
    logic [2:0] ext_lvl;
    logic [2:0] ext_en;
    logic [2:0] pin_wire;
    logic [2:0] pin_lvl;
    logic [2:0] pin_oe_n;
    tpm_pkg::tpm_capture_t cap [3];
    int err_total = 0;
    int checked = 0;

    tpm_top tpm_top_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .ch0_match_a_in(match_in[0]),
        .ch0_match_c_in(match_in[1]), .ch1_match_a_in(match_in[2]),
        .ch1_count_step_in(step_in), .ch0_counter_in(cnt0_in), .ch1_counter_in(cnt1_in),
        .ch0_pin_a_in(pin_wire[0]), .ch0_pin_c_in(pin_wire[1]), .ch1_pin_a_in(pin_wire[2]),
        .ch0_pin_a_out(pin_lvl[0]), .ch0_pin_a_oe_n_out(pin_oe_n[0]),
        .ch0_pin_c_out(pin_lvl[1]), .ch0_pin_c_oe_n_out(pin_oe_n[1]),
        .ch1_pin_a_out(pin_lvl[2]), .ch1_pin_a_oe_n_out(pin_oe_n[2]),
        .ch0_cap_a_out(cap[0]), .ch0_cap_c_out(cap[1]), .ch1_cap_a_out(cap[2])
    );

    tpm_pin_partner tpm_pin_partner_inst (
        .clk_in(clk_in), .ext_lvl_in(ext_lvl), .ext_en_in(ext_en),
        .dut_lvl_in(pin_lvl), .dut_oe_n_in(pin_oe_n), .wire_out(pin_wire)
    );

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compare and report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write on the plain register port
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask

    // One-cycle read, data taken in the following cycle only
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        @(negedge clk_in);
        d = rd_data_out;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check("register read", exp, d);
    endtask

    // One-cycle compare match strobe
    task automatic pulse_match(input int p);
        @(posedge clk_in);
        match_in[p] <= 1'b1;
        @(posedge clk_in);
        match_in[p] <= 1'b0;
    endtask

    // Count pulses on one capture output over a fixed window
    task automatic watch_cap(input int p, input int exp_n, input logic [15:0] exp_v);
        int n;
        logic [15:0] v;
        n = 0;
        v = '0;
        repeat (10) begin
            @(negedge clk_in);
            if (cap[p].pulse === 1'b1) begin
                n++;
                v = cap[p].value;
            end
        end
        check("capture pulses", exp_n, n);
        if (exp_n > 0) begin
            check("capture value", exp_v, v);
        end
    endtask

    // Guard against a hang
    initial begin
        repeat (30000) @(posedge clk_in);
        err_total++;
        $display("BAD run time limit expected end seen hang");
        wrap_up();
    end

    initial begin : main
        logic [15:0] cv;
        logic exp_lvl;
        addr_in = 3'h0;
        wr_data_in = 8'h00;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        match_in = 3'h0;
        step_in = 1'b0;
        cnt0_in = 16'h0000;
        cnt1_in = 16'h0000;
        ext_lvl = 3'h0;
        ext_en = 3'h7;
        sys_rst_in = 1'b1;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        // Reset values, read-back, read-only and unmapped places
        for (int a = 0; a < 4; a++) rd_chk(a[2:0], tpm_pkg::RST_CTRL);
        rd_chk(tpm_pkg::OFS_MODE_CTRL, tpm_pkg::RST_MODE);
        rd_chk(tpm_pkg::OFS_PIN_STATUS, 8'h70);
        for (int a = 0; a < 4; a++) reg_wr(a[2:0], 8'h90 + a[7:0]);
        for (int a = 0; a < 4; a++) rd_chk(a[2:0], 8'h90 + a[7:0]);
        reg_wr(tpm_pkg::OFS_PIN_STATUS, 8'h0f);
        // Fields 0001 and 0010 now drive pins C and ch1 A low; pin A stays off
        rd_chk(tpm_pkg::OFS_PIN_STATUS, 8'h10);
        rd_chk(3'h6, 8'h00);
        rd_chk(3'h7, 8'h00);
        $display("Test registers done");
        // Compare modes: initial level on write, action on match
        ext_en <= 3'h0;
        for (int p = 0; p < 3; p++) begin
            for (int f = 0; f < 8; f++) begin
                reg_wr(p[2:0], f[7:0]);
                repeat (3) @(negedge clk_in);
                check("pin enable", (f[1:0] == 2'b00), pin_oe_n[p]);
                if (f[1:0] != 2'b00) begin
                    check("initial level", f[2], pin_lvl[p]);
                    pulse_match(p);
                    @(negedge clk_in);
                    exp_lvl = (f[1:0] == 2'b11) ? ~f[2] : f[1];
                    check("match level", exp_lvl, pin_lvl[p]);
                end
            end
            reg_wr(p[2:0], 8'h00);
        end
        ext_en <= 3'h7;
        repeat (6) @(posedge clk_in);
        $display("Test compare done");
        // Pin capture on rising, falling and both edges
        for (int p = 0; p < 3; p++) begin
            for (int f = 8; f < 12; f++) begin
                cv = 16'h4a00 + 16'(p * 16 + f);
                reg_wr(p[2:0], f[7:0]);
                cnt0_in <= cv;
                cnt1_in <= ~cv;
                repeat (4) @(negedge clk_in);
                @(posedge clk_in);
                ext_lvl[p] <= 1'b1;
                watch_cap(p, (f != 9), (p == 2) ? ~cv : cv);
                @(posedge clk_in);
                ext_lvl[p] <= 1'b0;
                watch_cap(p, (f != 8), (p == 2) ? ~cv : cv);
            end
        end
        $display("Test pin capture done");
        // Count-step capture, blocked while prescale select is undivided
        reg_wr(tpm_pkg::OFS_MODE_CTRL, 8'h10);
        rd_chk(tpm_pkg::OFS_MODE_CTRL, 8'h10);
        reg_wr(tpm_pkg::OFS_CH0_CTRL_HIGH, 8'h0c);
        cnt0_in <= 16'h7e5a;
        @(posedge clk_in);
        step_in <= 1'b1;
        @(posedge clk_in);
        step_in <= 1'b0;
        watch_cap(0, 1, 16'h7e5a);
        reg_wr(tpm_pkg::OFS_MODE_CTRL, 8'h00);
        @(posedge clk_in);
        step_in <= 1'b1;
        @(posedge clk_in);
        step_in <= 1'b0;
        watch_cap(0, 0, 16'h0000);
        $display("Test count capture done");
        // Buffer mode silences register C
        reg_wr(tpm_pkg::OFS_MODE_CTRL, 8'h01);
        reg_wr(tpm_pkg::OFS_CH0_CTRL_LOW, 8'h03);
        repeat (3) @(negedge clk_in);
        pulse_match(1);
        @(negedge clk_in);
        check("buffered match level", 1'b0, pin_lvl[1]);
        reg_wr(tpm_pkg::OFS_CH0_CTRL_LOW, 8'h0a);
        repeat (6) @(posedge clk_in);
        ext_lvl[1] <= 1'b1;
        watch_cap(1, 0, 16'h0000);
        reg_wr(tpm_pkg::OFS_MODE_CTRL, 8'h00);
        $display("Test buffer mode done");
        // Channel 1 capture chained to channel 0 register A
        reg_wr(tpm_pkg::OFS_CH1_CTRL, 8'h0c);
        reg_wr(tpm_pkg::OFS_CH0_CTRL_HIGH, 8'h03);
        cnt1_in <= 16'h3cc3;
        repeat (3) @(negedge clk_in);
        pulse_match(0);
        watch_cap(2, 1, 16'h3cc3);
        reg_wr(tpm_pkg::OFS_CH0_CTRL_HIGH, 8'h08);
        cnt1_in <= 16'h5aa5;
        repeat (6) @(posedge clk_in);
        ext_lvl[0] <= 1'b1;
        watch_cap(2, 1, 16'h5aa5);
        $display("Test chained capture done");
        wrap_up();
    end
endmodule // timer_pin_io_mode_select_tb_top
